// *** hw/ars_defs.vh ***
// Constants of the asynchronous reset sequencer.
// Assumes a 250 MHz core clock; times are kept in their printed units.
`ifndef ARS_DEFS_VH
`define ARS_DEFS_VH

// Clock period and half clock period, picoseconds
`define ARS_CLK_PS 4000
`define ARS_HALF_CLOCK_PERIOD_PS 2000

// Input filter: spikes below this are rejected (least time, round up)
`define ARS_FILTER_NS 50
`define ARS_FILTER_CYCLES \
  ((`ARS_FILTER_NS * 1000 + `ARS_CLK_PS - 1) / `ARS_CLK_PS)

// Flash initialisation, longest time (round down)
`define ARS_FLASH_INIT_NS 1000000
`define ARS_FLASH_INIT_CYCLES \
  ((`ARS_FLASH_INIT_NS * 1000) / `ARS_CLK_PS)

// External boot release delay: 3 to 8 half clock periods (round down)
`define ARS_EXT_DELAY_TCL 8
`define ARS_EXT_DELAY_CYCLES \
  ((`ARS_EXT_DELAY_TCL * `ARS_HALF_CLOCK_PERIOD_PS) / `ARS_CLK_PS)

// Early flash read phase that answers all ones
`define ARS_FLASH_BLANK_CYCLES 64

// Flash answers during initialisation
`define ARS_FLASH_BLANK_DATA 16'hFFFF
`define ARS_FLASH_EARLY_DATA 16'h009B

// Start of fetch: address 00'0000h in code segment 0
`define ARS_START_ADDR 24'h00_0000

// Sequencer states
`define ARS_ST_RESET 2'h0
`define ARS_ST_FLASH 2'h1
`define ARS_ST_EXT 2'h2
`define ARS_ST_RUN 2'h3

`endif

// *** hw/ars_filter.v ***
// Pin synchroniser and spike filter for one reset pin.
// Assumes a raw pin input; output changes only after a stable run.
`timescale 1ns/1ps
module ars_filter #(
  parameter integer STABLE_CYCLES = 13,
  parameter integer CNT_W = 8,
  parameter RESET_LEVEL = 1'b0
) (
  input wire core_clk,
  input wire arst_n,
  input wire pin,
  output reg level
);
  reg sync_a;
  reg sync_b;
  reg [CNT_W-1:0] stable_cnt;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= RESET_LEVEL;
      sync_b <= RESET_LEVEL;
      stable_cnt <= {CNT_W{1'b0}};
      level <= RESET_LEVEL;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      // Count how long the synced pin differs from the filtered level
      if (sync_b == level) begin
        stable_cnt <= {CNT_W{1'b0}};
      end else if (stable_cnt == STABLE_CYCLES[CNT_W-1:0] - 1'b1) begin
        stable_cnt <= {CNT_W{1'b0}};
        level <= sync_b;
      end else begin
        stable_cnt <= stable_cnt + 1'b1;
      end
    end
  end
endmodule

// *** hw/ars_sequencer.v ***
// Asynchronous reset sequencer: entry, forced state, exit and flags.
// Assumes raw board pins in and core logic strobes from the same clock.
//
// How it works
// - Reset pin low with mode pin low forces reset state after the filter.
// - Entry drops reset out, cancels holds, aborts bus, floats, pulls port.
// - Detection needs no settled clock (code detects through the core_clk sync and filter); power-on reset acts asynchronously.
// - Internal flash boot holds internal reset until flash init ends.
// - External boot releases after filter plus 3 to 8 half clocks; code releases 10 half clocks (5 clocks) after the filtered pin rises.
// - Early flash reads answer FFFFh first, then 009Bh.
// - Flash init uses its own timer, not the system clock settling.
// - Reset pin already low and mode pin falling also enters reset.
// - Leaving reset latches the configuration port.
// - Reset holds address latch, read and write strobes inactive until release.
// - Fetch starts at address zero in code segment zero.
// - Filter rejects spikes under 50 ns, accepts pulses over 500 ns.
// - Power-on and cold hardware reset each set their own flag.
`timescale 1ns/1ps
`include "ars_defs.vh"
module ars_sequencer #(
  parameter integer FLASH_INIT_CYCLES = `ARS_FLASH_INIT_CYCLES,
  parameter integer FLASH_BLANK_CYCLES = `ARS_FLASH_BLANK_CYCLES,
  parameter integer EXT_DELAY_CYCLES = `ARS_EXT_DELAY_CYCLES,
  parameter integer FILTER_CYCLES = `ARS_FILTER_CYCLES,
  parameter integer CFG_W = 16
) (
  input wire core_clk,
  input wire arst_n,
  input wire reset_in_n,
  input wire reset_mode_pin,
  input wire external_boot_n,
  input wire [CFG_W-1:0] configuration_port,
  input wire cpu_ale,
  input wire cpu_rd_n,
  input wire cpu_write_strobe_n,
  input wire flash_read_req,
  input wire [15:0] flash_data_in,
  input wire flag_clear,
  output reg reset_out_n,
  output reg core_reset_n,
  output reg hold_cancel,
  output reg bus_abort,
  output reg bus_drive_en,
  output reg config_pull_en,
  output reg [CFG_W-1:0] config_latched,
  output reg fetch_start,
  output reg [23:0] fetch_addr,
  output reg ale,
  output reg rd_n,
  output reg write_strobe_n,
  output reg flash_ready,
  output reg [15:0] flash_read_data,
  output reg power_on_flag,
  output reg long_hw_reset_flag
);
  localparam [1:0] ST_RESET = `ARS_ST_RESET;
  localparam [1:0] ST_FLASH = `ARS_ST_FLASH;
  localparam [1:0] ST_EXT = `ARS_ST_EXT;
  localparam [1:0] ST_RUN = `ARS_ST_RUN;
  localparam integer CNT_W = 20;

  wire rin_level;
  wire mode_level;
  reg boot_sync_a;
  reg boot_sync_b;
  reg [CFG_W-1:0] cfg_sync_a;
  reg [CFG_W-1:0] cfg_sync_b;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [CNT_W-1:0] seq_cnt;
  reg [CNT_W-1:0] next_seq_cnt;
  reg internal_boot;
  reg cold_hit;
  reg in_reset;
  // Background flash timer and its done flag
  reg [CNT_W-1:0] flash_age;
  reg seq_ext_done;

  // Both reset pins are filtered after two sync flops
  ars_filter #(
    .STABLE_CYCLES(FILTER_CYCLES),
    .CNT_W(8),
    .RESET_LEVEL(1'b0)
  ) u_rin_filter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(reset_in_n),
    .level(rin_level)
  );

  ars_filter #(
    .STABLE_CYCLES(FILTER_CYCLES),
    .CNT_W(8),
    .RESET_LEVEL(1'b0)
  ) u_mode_filter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin(reset_mode_pin),
    .level(mode_level)
  );

  // Boot select and configuration port are plain pins
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_sync_a <= 1'b1;
      boot_sync_b <= 1'b1;
      cfg_sync_a <= {CFG_W{1'b1}};
      cfg_sync_b <= {CFG_W{1'b1}};
    end else begin
      boot_sync_a <= external_boot_n;
      boot_sync_b <= boot_sync_a;
      cfg_sync_a <= configuration_port;
      cfg_sync_b <= cfg_sync_a;
    end
  end

  // Cold entry: both filtered levels low, whichever fell last
  always @* begin
    cold_hit = !rin_level && !mode_level;
  end

  always @* begin
    next_state = state;
    next_seq_cnt = seq_cnt;
    case (state)
      ST_RESET: begin
        // Stay here while the filtered reset pin is low
        next_seq_cnt = {CNT_W{1'b0}};
        if (rin_level) begin
          if (boot_sync_b) begin
            next_state = ST_FLASH;
          end else begin
            next_state = ST_EXT;
          end
        end
      end
      ST_FLASH: begin
        // Flash timer only needs the core supply, not a settled clock
        if (seq_cnt == FLASH_INIT_CYCLES[CNT_W-1:0] - 1'b1) begin
          next_state = ST_RUN;
        end else begin
          next_seq_cnt = seq_cnt + 1'b1;
        end
      end
      ST_EXT: begin
        // Release a fixed count of clocks after the filtered pin rises
        if (seq_cnt == EXT_DELAY_CYCLES[CNT_W-1:0] - 1'b1) begin
          next_state = ST_RUN;
        end else begin
          next_seq_cnt = seq_cnt + 1'b1;
        end
      end
      default: begin
        // Running: counter idles at zero
        next_seq_cnt = {CNT_W{1'b0}};
      end
    endcase
    if (cold_hit) begin
      next_state = ST_RESET;
      next_seq_cnt = {CNT_W{1'b0}};
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RESET;
      seq_cnt <= {CNT_W{1'b0}};
    end else begin
      state <= next_state;
      seq_cnt <= next_seq_cnt;
    end
  end

  // Outputs follow the next state so they switch on the state edge
  always @* begin
    in_reset = (next_state != ST_RUN);
  end

  // Forced reset state and release
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_out_n <= 1'b0;
      core_reset_n <= 1'b0;
      hold_cancel <= 1'b1;
      bus_abort <= 1'b1;
      bus_drive_en <= 1'b0;
      config_pull_en <= 1'b1;
      ale <= 1'b0;
      rd_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      core_reset_n <= !in_reset;
      reset_out_n <= !in_reset;
      hold_cancel <= (next_state == ST_RESET);
      bus_abort <= (next_state == ST_RESET);
      bus_drive_en <= !in_reset;
      config_pull_en <= (next_state == ST_RESET);
      if (in_reset) begin
        ale <= 1'b0;
        rd_n <= 1'b1;
        write_strobe_n <= 1'b1;
      end else begin
        ale <= cpu_ale;
        rd_n <= cpu_rd_n;
        write_strobe_n <= cpu_write_strobe_n;
      end
    end
  end

  // Configuration latch and start of fetch on the release edge
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      config_latched <= {CFG_W{1'b1}};
      fetch_start <= 1'b0;
      fetch_addr <= `ARS_START_ADDR;
    end else begin
      fetch_start <= 1'b0;
      if (state != ST_RUN && next_state == ST_RUN) begin
        config_latched <= cfg_sync_b;
        fetch_start <= 1'b1;
        fetch_addr <= `ARS_START_ADDR;
      end
    end
  end

  // Boot source remembered for the flash read answers
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      internal_boot <= 1'b1;
    end else if (state == ST_RESET) begin
      internal_boot <= boot_sync_b;
    end
  end

  // Flash ready once its init timer has run out; an early read gets
  // all ones first and the illegal opcode value afterwards
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_ready <= 1'b0;
      flash_read_data <= `ARS_FLASH_BLANK_DATA;
    end else begin
      if (state == ST_RESET) begin
        flash_ready <= 1'b0;
      end else if (state == ST_FLASH &&
                   next_state == ST_RUN) begin
        flash_ready <= 1'b1;
      end else if (state == ST_RUN && !internal_boot &&
                   seq_ext_done) begin
        flash_ready <= 1'b1;
      end
      if (!flash_read_req) begin
        flash_read_data <= flash_read_data;
      end else if (flash_ready) begin
        flash_read_data <= flash_data_in;
      end else if (flash_age < FLASH_BLANK_CYCLES[CNT_W-1:0]) begin
        flash_read_data <= `ARS_FLASH_BLANK_DATA;
      end else begin
        flash_read_data <= `ARS_FLASH_EARLY_DATA;
      end
    end
  end

  // Flash init time is counted separately so external boot can run
  // while the flash still initialises in the background
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_age <= {CNT_W{1'b0}};
      seq_ext_done <= 1'b0;
    end else if (state == ST_RESET) begin
      flash_age <= {CNT_W{1'b0}};
      seq_ext_done <= 1'b0;
    end else if (flash_age == FLASH_INIT_CYCLES[CNT_W-1:0] - 1'b1) begin
      seq_ext_done <= 1'b1;
    end else begin
      flash_age <= flash_age + 1'b1;
    end
  end

  // Reset cause flags; a new cause wins over a clear in the same cycle
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_on_flag <= 1'b1;
      long_hw_reset_flag <= 1'b0;
    end else begin
      // Power-on flag is set only by the power-on reset itself
      if (flag_clear) begin
        power_on_flag <= 1'b0;
      end
      if (cold_hit && state != ST_RESET) begin
        long_hw_reset_flag <= 1'b1;
      end else if (flag_clear) begin
        long_hw_reset_flag <= 1'b0;
      end
    end
  end
endmodule

// *** verif/ars_board.sv ***
// Board supervisor model: drives reset, mode, boot and config pins.
// Assumes the bench calls its tasks; pins change just after core_clk rises.
`timescale 1ns/1ps
module ars_board #(
  parameter integer PWR_HOLD = 300
) (
  input wire core_clk,
  output reg reset_in_n,
  output reg reset_mode_pin,
  output reg external_boot_n,
  output reg [15:0] configuration_port
);
  // Powered with reset and mode pins held at ground
  initial begin
    reset_in_n = 1'b0;
    reset_mode_pin = 1'b0;
    external_boot_n = 1'b0;
    configuration_port = 16'hffff;
  end
  // Cold reset; mode may fall late; pins settle while reset is low
  task automatic cold(input int lo, input int late, input logic boot,
    input logic [15:0] cfg);
    @(posedge core_clk);
    reset_in_n <= 1'b0;
    reset_mode_pin <= late == 0 ? 1'b0 : 1'b1;
    repeat (late) @(posedge core_clk);
    if (late != 0) reset_mode_pin <= 1'b0;
    repeat (20) @(posedge core_clk);
    external_boot_n <= boot;
    configuration_port <= cfg;
    repeat (lo) @(posedge core_clk);
    reset_in_n <= 1'b1;
  endtask
  // Hold time shortened like the flash timer
  task automatic power_on(input logic boot, input logic [15:0] cfg);
    cold(PWR_HOLD, 0, boot, cfg);
  endtask
  // Pulse on the reset pin with a chosen mode level
  task automatic pulse(input int lo, input logic mode);
    @(posedge core_clk);
    reset_in_n <= 1'b0;
    reset_mode_pin <= mode;
    repeat (lo) @(posedge core_clk);
    reset_in_n <= 1'b1;
  endtask
endmodule

// *** verif/ars_seq_chk.sv ***
// Checker for the reset sequencer: entry, release and strobe relations.
// Assumes a bind to ars_sequencer and sees its ports only.
`timescale 1ns/1ps
module ars_seq_chk (
  input wire core_clk,
  input wire arst_n,
  input wire reset_in_n,
  input wire reset_mode_pin,
  input wire external_boot_n,
  input wire reset_out_n,
  input wire core_reset_n,
  input wire hold_cancel,
  input wire bus_drive_en,
  input wire config_pull_en,
  input wire fetch_start,
  input wire [23:0] fetch_addr,
  input wire ale,
  input wire rd_n,
  input wire write_strobe_n,
  input wire flash_ready,
  input wire long_hw_reset_flag
);
  // Length of the current run with both pins low
  logic [7:0] low_run;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_run <= 8'h00;
    end else if (reset_in_n || reset_mode_pin) begin
      low_run <= 8'h00;
    end else if (low_run != 8'hff) begin
      low_run <= low_run + 8'h01;
    end
  end
  // Length of the current run with the reset pin low, any mode level
  logic [7:0] rin_run;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rin_run <= 8'h00;
    end else if (reset_in_n) begin
      rin_run <= 8'h00;
    end else if (rin_run != 8'hff) begin
      rin_run <= rin_run + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence held_s; !core_reset_n && !reset_out_n; endsequence
  sequence run_s; core_reset_n && reset_out_n && bus_drive_en; endsequence
  sequence leave_s; $fell(hold_cancel); endsequence
  entry_force_a: assert property (low_run == 8'h14 |->
    hold_cancel && !reset_out_n && !bus_drive_en && config_pull_en)
    else $error("cold entry did not force reset state");
  spike_rej_a: assert property ($fell(reset_out_n) |->
    $past(rin_run, 3) >= 8'h0a) else $error("short spike entered reset");
  out_pair_a: assert property (reset_out_n == core_reset_n)
    else $error("reset out differs from internal reset");
  quiet_strobe_a: assert property (!core_reset_n |->
    !ale && rd_n && write_strobe_n && !bus_drive_en)
    else $error("strobe or bus active in reset");
  fetch_start_a: assert property ($rose(core_reset_n) |->
    fetch_start && fetch_addr == 24'h00_0000) else $error("bad fetch start");
  ext_release_a: assert property (leave_s and !external_boot_n |->
    held_s ##[2:6] run_s) else $error("external boot release late");
  flash_wait_a: assert property (leave_s and external_boot_n |->
    held_s [*8]) else $error("flash boot released early");
  flash_ready_a: assert property (core_reset_n && external_boot_n |->
    flash_ready) else $error("running before flash ready");
  cause_flag_a: assert property ($fell(reset_out_n) |->
    ##[0:2] long_hw_reset_flag) else $error("cold reset flag not set");
endmodule
bind ars_sequencer ars_seq_chk chk (.core_clk, .arst_n, .reset_in_n,
  .reset_mode_pin, .external_boot_n, .reset_out_n, .core_reset_n,
  .hold_cancel, .bus_drive_en, .config_pull_en, .fetch_start, .fetch_addr,
  .ale, .rd_n, .write_strobe_n, .flash_ready, .long_hw_reset_flag);

// *** verif/tb_top.sv ***
// Top bench for the reset sequencer with board model and checker.
// Assumes hw and verif files compiled together; 250 MHz core clock.
`timescale 1ns/1ps
module tb_top;
  localparam int FINIT = 200;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cpu_ale = 1'b0, cpu_rd_n = 1'b1, cpu_write_strobe_n = 1'b1;
  logic flash_read_req = 1'b0, flag_clear = 1'b0, ext;
  logic [15:0] flash_data_in = 16'h0000, cfg, d;
  wire reset_in_n, reset_mode_pin, external_boot_n, bus_abort, hold_cancel;
  wire [15:0] configuration_port, config_latched, flash_read_data;
  wire reset_out_n, core_reset_n, bus_drive_en, config_pull_en, fetch_start;
  wire ale, rd_n, write_strobe_n, flash_ready, power_on_flag;
  wire long_hw_reset_flag;
  wire [23:0] fetch_addr;
  int failures = 0, tests_run = 0, n, late;
  always #2 core_clk = ~core_clk;
  ars_board brd (.core_clk, .reset_in_n, .reset_mode_pin, .external_boot_n,
    .configuration_port);
  ars_sequencer #(.FLASH_INIT_CYCLES(FINIT), .FLASH_BLANK_CYCLES(16)) uut (
    .core_clk, .arst_n, .reset_in_n, .reset_mode_pin, .external_boot_n,
    .configuration_port, .cpu_ale, .cpu_rd_n, .cpu_write_strobe_n,
    .flash_read_req, .flash_data_in, .flag_clear, .reset_out_n, .core_reset_n,
    .hold_cancel, .bus_abort, .bus_drive_en, .config_pull_en, .config_latched,
    .fetch_start, .fetch_addr, .ale, .rd_n, .write_strobe_n, .flash_ready,
    .flash_read_data, .power_on_flag, .long_hw_reset_flag);
  function automatic logic [15:0] rd_exp(input logic rdy, input logic blank);
    return rdy ? flash_data_in : (blank ? 16'hffff : 16'h009b);
  endfunction
  task chk(input string nm, input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_rng(input string nm, input int g, input int lo, input int hi);
    tests_run++;
    if (g < lo || g > hi) begin
      failures++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task boot(input logic e, input logic [15:0] c);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (e) chk_rng("flash boot delay", n, FINIT, FINIT + 25);
    else chk_rng("ext boot delay", n, 15, 24);
    chk("fetch_start", fetch_start, 1'b1);
    chk("fetch_addr", fetch_addr, 24'h00_0000);
    chk("config_latched", config_latched, c);
    chk("reset_out_n", reset_out_n, 1'b1);
    chk("flash_ready", flash_ready, e);
  endtask
  task rd(input logic rdy, input logic blank);
    @(posedge core_clk);
    flash_read_req <= 1'b1;
    @(posedge core_clk);
    flash_read_req <= 1'b0;
    #1 chk("flash_read_data", flash_read_data, rd_exp(rdy, blank));
  endtask
  task clr;
    @(posedge core_clk);
    flag_clear <= 1'b1;
    @(posedge core_clk);
    flag_clear <= 1'b0;
    #1 chk("power_on_flag", power_on_flag, 1'b0);
  endtask
  initial begin
    void'($urandom(32'h8873_2f39));
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk("power_on_flag", power_on_flag, 1'b1);
    chk("hold_cancel", hold_cancel, 1'b1);
    chk("config_pull_en", config_pull_en, 1'b1);
    chk("bus_abort", bus_abort, 1'b1);
    brd.power_on(1'b0, 16'h5a3c);
    boot(1'b0, 16'h5a3c);
    chk("long_hw_reset_flag", long_hw_reset_flag, 1'b0);
    rd(1'b0, 1'b1);
    repeat (20) @(posedge core_clk);
    rd(1'b0, 1'b0);
    repeat (FINIT) @(posedge core_clk);
    flash_data_in <= 16'($urandom);
    rd(1'b1, 1'b0);
    clr();
    brd.pulse(8, 1'b0);
    repeat (30) @(posedge core_clk);
    #1 chk("spike reset_out_n", reset_out_n, 1'b1);
    brd.pulse(40, 1'b1);
    repeat (30) @(posedge core_clk);
    #1 chk("warm reset_out_n", reset_out_n, 1'b1);
    for (int i = 0; i < 6; i++) begin
      {cfg, d} = $urandom;
      // First pass boots from flash, second enters by a late mode fall
      ext = (i == 0) ? 1'b1 : d[0];
      late = (i == 1 || d[4]) ? 40 : 0;
      @(posedge core_clk);
      {cpu_ale, cpu_rd_n, cpu_write_strobe_n} <= d[3:1];
      repeat (2) @(posedge core_clk);
      #1 chk("strobes", {ale, rd_n, write_strobe_n}, d[3:1]);
      brd.cold(110 + $urandom % 20, late, ext, cfg);
      #1 chk("bus_drive_en", bus_drive_en, 1'b0);
      chk("bus_abort", bus_abort, 1'b1);
      boot(ext, cfg);
      chk("long_hw_reset_flag", long_hw_reset_flag, 1'b1);
      clr();
    end
    wrap_up();
  end
  initial begin
    #100_000;
    failures++;
    wrap_up();
  end
endmodule
